// ==== core/ssd_regs.vh ====
// Purpose: Opcode patterns and field positions for the slice decoder
// Assumes: Byte-wide instruction stream, first byte then operand-mode byte
// Notes: Definitions only
`ifndef SSD_REGS_VH
`define SSD_REGS_VH
// First-byte patterns
`define SSD_OP_SHIFT1 8'hd0
`define SSD_OP_SHIFTCL 8'hd2
`define SSD_OP_SHIFTN 8'hc0
`define SSD_MASK_W 8'hfe
`define SSD_OP_RET_NEAR_IMM 8'hc2
`define SSD_OP_RET_NEAR 8'hc3
`define SSD_OP_RET_FAR_IMM 8'hca
`define SSD_OP_RET_FAR 8'hcb
`define SSD_OP_SBB_RM 8'h18
`define SSD_MASK_DW 8'hfc
`define SSD_OP_SBB_IMM 8'h80
`define SSD_OP_SBB_ACC 8'h1c
`define SSD_OP_SCAN 8'hae
`define SSD_OP_STRING_COMPARE 8'ha6
`define SSD_OP_INS 8'h6c
`define SSD_OP_OUTS 8'h6e
`define SSD_OP_LODS 8'hac
`define SSD_OP_MOVS 8'ha4
`define SSD_OP_STOS 8'haa
`define SSD_OP_SS_PFX 8'h36
`define SSD_OP_REP 8'hf3
`define SSD_OP_REPNE 8'hf2
// Operand-mode middle field
`define SSD_MF_ROL 3'h0
`define SSD_MF_ROR 3'h1
`define SSD_MF_RCL 3'h2
`define SSD_MF_RCR 3'h3
`define SSD_MF_SHL 3'h4
`define SSD_MF_SHR 3'h5
`define SSD_MF_SAR 3'h7
`define SSD_MF_SBB 3'h3
`define SSD_MF_HI 5
`define SSD_MF_LO 3
// Field positions in the first byte
`define SSD_W_BIT 0
`define SSD_D_BIT 1
// Operation codes on op_q output
`define SSD_K_NONE 5'h00
`define SSD_K_RCL 5'h01
`define SSD_K_RCR 5'h02
`define SSD_K_SHL 5'h03
`define SSD_K_ROL 5'h04
`define SSD_K_ROR 5'h05
`define SSD_K_SHR 5'h06
`define SSD_K_SAR 5'h07
`define SSD_K_RETN 5'h08
`define SSD_K_RETF 5'h09
`define SSD_K_SBB 5'h0a
`define SSD_K_SCAN 5'h0b
`define SSD_K_STRING_COMPARE 5'h0c
`define SSD_K_INS 5'h0d
`define SSD_K_OTHERSTR 5'h0e
`define SSD_K_UNDEF 5'h1f
// Repeat kinds
`define SSD_RP_NONE 2'h0
`define SSD_RP_COUNT 2'h1
`define SSD_RP_EQ 2'h2
`define SSD_RP_NE 2'h3
// Shift-count forms
`define SSD_CNT_ONE 2'h0
`define SSD_CNT_CL 2'h1
`define SSD_CNT_IMM 2'h2
`endif

// ==== core/ssd_imm16.v ====
// Purpose: Collects a two-byte immediate, low byte first
// Assumes: Bytes arrive from same-clock fetch logic
// Notes: done pulses one cycle with the word on imm
`timescale 1ns/100ps
`default_nettype none
module ssd_imm16 #(
  parameter W = 16
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Control
  input wire start,
  input wire byte_valid,
  input wire [7:0] byte_in,
  // Result
  output reg busy_q,
  output reg done_q,
  output reg [W-1:0] imm_q
);
  reg hi_q;
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
      hi_q <= 1'b0;
      imm_q <= {W{1'b0}};
    end
    else
    begin
      done_q <= 1'b0;
      if (start)
      begin
        busy_q <= 1'b1;
        hi_q <= 1'b0;
      end
      else if (busy_q && byte_valid)
      begin
        if (!hi_q)
        begin
          imm_q[7:0] <= byte_in;
          hi_q <= 1'b1;
        end
        else
        begin
          imm_q[W-1:8] <= byte_in;
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== core/ssd_prefix.v ====
// Purpose: Holds pending segment and repeat prefixes
// Assumes: Cleared when a non-prefix instruction is issued
// Notes: Last repeat prefix seen wins
`timescale 1ns/100ps
`default_nettype none
`include "ssd_regs.vh"
module ssd_prefix (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Control
  input wire take,
  input wire [7:0] byte_in,
  input wire consume,
  // State
  output reg ss_q,
  output reg [1:0] rep_q
);
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ss_q <= 1'b0;
      rep_q <= `SSD_RP_NONE;
    end
    else if (take)
    begin
      if (byte_in == `SSD_OP_SS_PFX)
        ss_q <= 1'b1;
      else if (byte_in == `SSD_OP_REP)
        rep_q <= `SSD_RP_COUNT;
      else if (byte_in == `SSD_OP_REPNE)
        rep_q <= `SSD_RP_NE;
    end
    else if (consume)
    begin
      ss_q <= 1'b0;
      rep_q <= `SSD_RP_NONE;
    end
  end
endmodule
`default_nettype wire

// ==== core/ssd_decoder.v ====
// Function
// - Shift group middle 010: rotate left carry
// - Shift group middle 011: rotate right carry
// - Shift group middle 100: shift left
// - C2 near return, two immediate bytes
// - CA far return, two immediate bytes
// - 0001 10dw subtract with borrow, d, w
// - 1010 111w string scan, width bit
// - 36 prefix forces stack segment
// - F3 before string op repeats by count
// - F3 before compare or scan: while equal
// - F2 before compare or scan: while not equal
// - Repeat allowed before string port input
//
// Purpose: Decodes one slice of the instruction set from the byte stream
// Assumes: Fetch logic on clk presents one byte per byte_valid
// Notes: One decoded instruction per issue_q pulse
`timescale 1ns/100ps
`default_nettype none
`include "ssd_regs.vh"
module ssd_decoder #(
  parameter IMM_W = 16
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Fetch stream
  input wire byte_valid,
  input wire [7:0] byte_in,
  // Decoded instruction
  output reg issue_q,
  output reg [4:0] op_q,
  output reg width_word_q,
  output reg dir_q,
  output reg [1:0] count_form_q,
  output reg [7:0] modrm_q,
  output reg [IMM_W-1:0] imm_q,
  output reg imm_valid_q,
  output reg stack_seg_q,
  output reg [1:0] repeat_q,
  output reg use_count_reg_q,
  output reg port_from_dx_q,
  output reg undefined_q
);
  // One-hot fetch states
  localparam ST_OP = 3'b001;
  localparam ST_MODRM = 3'b010;
  localparam ST_IMM = 3'b100;

  reg [2:0] state_q;
  reg [7:0] op1_q;
  reg [4:0] op_d;
  reg undef_d;
  reg [1:0] cnt_d;
  reg [1:0] rep_d;
  reg is_shift;
  reg is_pfx;
  reg is_str;
  reg is_cmp_scan;
  reg need_modrm;
  reg need_imm;
  wire [2:0] mf;
  wire [7:0] cur_op;
  wire imm_busy;
  wire imm_done;
  wire [IMM_W-1:0] imm_word;
  wire pfx_ss;
  wire [1:0] pfx_rep;
  wire take_op;
  wire issue_now;

  // Opcode byte is only taken between instructions
  assign take_op = byte_valid && (state_q == ST_OP);
  // Later states decode from the held first byte
  assign cur_op = (state_q == ST_OP) ? byte_in : op1_q;
  // Middle field read straight off the stream; only
  // meaningful while the operand-mode byte is offered
  assign mf = byte_in[`SSD_MF_HI:`SSD_MF_LO];

  // Opcode class
  always @*
  begin
    is_shift = ((cur_op & `SSD_MASK_W) == `SSD_OP_SHIFT1) ||
      ((cur_op & `SSD_MASK_W) == `SSD_OP_SHIFTCL) ||
      ((cur_op & `SSD_MASK_W) == `SSD_OP_SHIFTN);
    is_pfx = (cur_op == `SSD_OP_SS_PFX) || (cur_op == `SSD_OP_REP) ||
      (cur_op == `SSD_OP_REPNE);
    is_cmp_scan = ((cur_op & `SSD_MASK_W) == `SSD_OP_SCAN) ||
      ((cur_op & `SSD_MASK_W) == `SSD_OP_STRING_COMPARE);
    is_str = is_cmp_scan || ((cur_op & `SSD_MASK_W) == `SSD_OP_INS) ||
      ((cur_op & `SSD_MASK_W) == `SSD_OP_OUTS) ||
      ((cur_op & `SSD_MASK_W) == `SSD_OP_LODS) ||
      ((cur_op & `SSD_MASK_W) == `SSD_OP_MOVS) ||
      ((cur_op & `SSD_MASK_W) == `SSD_OP_STOS);
    // Count byte of the by-count shift is left to the next opcode
    need_modrm = is_shift ||
      ((cur_op & `SSD_MASK_DW) == `SSD_OP_SBB_RM) ||
      ((cur_op & `SSD_MASK_DW) == `SSD_OP_SBB_IMM);
    need_imm = (cur_op == `SSD_OP_RET_NEAR_IMM) ||
      (cur_op == `SSD_OP_RET_FAR_IMM);
  end

  // Operation from bytes
  always @*
  begin
    op_d = `SSD_K_UNDEF;
    undef_d = 1'b0;
    cnt_d = `SSD_CNT_ONE;
    if ((cur_op & `SSD_MASK_W) == `SSD_OP_SHIFTCL)
      cnt_d = `SSD_CNT_CL;
    else if ((cur_op & `SSD_MASK_W) == `SSD_OP_SHIFTN)
      cnt_d = `SSD_CNT_IMM;
    if (is_shift)
    begin
      case (mf)
        `SSD_MF_RCL: op_d = `SSD_K_RCL;
        `SSD_MF_RCR: op_d = `SSD_K_RCR;
        `SSD_MF_SHL: op_d = `SSD_K_SHL;
        `SSD_MF_ROL: op_d = `SSD_K_ROL;
        `SSD_MF_ROR: op_d = `SSD_K_ROR;
        `SSD_MF_SHR: op_d = `SSD_K_SHR;
        `SSD_MF_SAR: op_d = `SSD_K_SAR;
        default: undef_d = 1'b1;
      endcase
    end
    else if ((cur_op & `SSD_MASK_DW) == `SSD_OP_SBB_RM)
      op_d = `SSD_K_SBB;
    else if ((cur_op & `SSD_MASK_DW) == `SSD_OP_SBB_IMM)
    begin
      if (mf == `SSD_MF_SBB)
        op_d = `SSD_K_SBB;
      else
        undef_d = 1'b1;
    end
    else if ((cur_op & `SSD_MASK_W) == `SSD_OP_SBB_ACC)
      op_d = `SSD_K_SBB;
    else if ((cur_op == `SSD_OP_RET_NEAR_IMM) ||
      (cur_op == `SSD_OP_RET_NEAR))
      op_d = `SSD_K_RETN;
    else if ((cur_op == `SSD_OP_RET_FAR_IMM) ||
      (cur_op == `SSD_OP_RET_FAR))
      op_d = `SSD_K_RETF;
    else if ((cur_op & `SSD_MASK_W) == `SSD_OP_SCAN)
      op_d = `SSD_K_SCAN;
    else if ((cur_op & `SSD_MASK_W) == `SSD_OP_STRING_COMPARE)
      op_d = `SSD_K_STRING_COMPARE;
    else if ((cur_op & `SSD_MASK_W) == `SSD_OP_INS)
      op_d = `SSD_K_INS;
    else if (is_str)
      op_d = `SSD_K_OTHERSTR;
    else
      op_d = `SSD_K_NONE;
  end

  // Repeat kind depends on compare or scan
  always @*
  begin
    rep_d = `SSD_RP_NONE;
    if (is_str)
    begin
      if (pfx_rep == `SSD_RP_COUNT && is_cmp_scan)
        rep_d = `SSD_RP_EQ;
      else if (pfx_rep == `SSD_RP_COUNT)
        rep_d = `SSD_RP_COUNT;
      else if (pfx_rep == `SSD_RP_NE && is_cmp_scan)
        rep_d = `SSD_RP_NE;
      // Repeat-not-equal on non-compare acts as count only
      else if (pfx_rep == `SSD_RP_NE)
        rep_d = `SSD_RP_COUNT;
    end
  end

  // Issue on the byte that completes an instruction, or in the cycle after an immediate's high byte;
  // prefixes never issue on their own
  assign issue_now = (take_op && !is_pfx && !need_modrm && !need_imm) ||
    (byte_valid && state_q == ST_MODRM) || imm_done;

  // Immediate collector
  ssd_imm16 #(
    .W(IMM_W)
  ) u_imm (
    .clk(clk),
    .rst(rst),
    .start(take_op && need_imm),
    .byte_valid(byte_valid && state_q == ST_IMM),
    .byte_in(byte_in),
    .busy_q(imm_busy),
    .done_q(imm_done),
    .imm_q(imm_word)
  );

  ssd_prefix u_pfx (
    .clk(clk),
    .rst(rst),
    .take(take_op && is_pfx),
    .byte_in(byte_in),
    .consume(issue_now),
    .ss_q(pfx_ss),
    .rep_q(pfx_rep)
  );

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_q <= ST_OP;
      op1_q <= 8'h00;
    end
    // Fetch sequencing
    else
    begin
      case (state_q)
        ST_OP:
        begin
          if (take_op && !is_pfx)
          begin
            op1_q <= byte_in;
            if (need_modrm)
              state_q <= ST_MODRM;
            else if (need_imm)
              state_q <= ST_IMM;
          end
        end
        ST_MODRM:
        begin
          if (byte_valid)
            state_q <= ST_OP;
        end
        ST_IMM:
        begin
          // Leaves once both bytes are in
          // Limitation: no stall path, so a byte offered in the
          // cycle the immediate completes is not taken
          if (!imm_busy && imm_done)
            state_q <= ST_OP;
        end
        default: state_q <= ST_OP;
      endcase
    end
  end

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      issue_q <= 1'b0;
      op_q <= `SSD_K_NONE;
      width_word_q <= 1'b0;
      dir_q <= 1'b0;
      count_form_q <= `SSD_CNT_ONE;
      modrm_q <= 8'h00;
      imm_q <= {IMM_W{1'b0}};
      imm_valid_q <= 1'b0;
      stack_seg_q <= 1'b0;
      repeat_q <= `SSD_RP_NONE;
      use_count_reg_q <= 1'b0;
      port_from_dx_q <= 1'b0;
      undefined_q <= 1'b0;
    end
    else
    begin
      issue_q <= issue_now;
      // Outputs hold until the next issue
      if (issue_now)
      begin
        op_q <= op_d;
        // Width and direction bits straight from the first byte
        width_word_q <= cur_op[`SSD_W_BIT];
        dir_q <= cur_op[`SSD_D_BIT];
        count_form_q <= cnt_d;
        // Operand-mode byte only for two-byte forms
        modrm_q <= (state_q == ST_MODRM) ? byte_in : 8'h00;
        imm_q <= imm_done ? imm_word : {IMM_W{1'b0}};
        imm_valid_q <= imm_done;
        stack_seg_q <= pfx_ss;
        repeat_q <= rep_d;
        use_count_reg_q <= (rep_d != `SSD_RP_NONE) ||
          (is_shift && cnt_d == `SSD_CNT_CL);
        port_from_dx_q <= (op_d == `SSD_K_INS);
        undefined_q <= undef_d;
      end
    end
  end
endmodule
`default_nettype wire

// ==== verif/ssd_chk_assertions.sv ====
// Purpose: Port checker for the slice decoder
// Assumes: Bytes taken on clk, issue one cycle later, two after an immediate's high byte
// Notes: Only relations visible at the ports
`timescale 1ns/100ps
`default_nettype none
`include "ssd_regs.vh"
module ssd_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Fetch stream
  input wire logic byte_valid,
  input wire logic [7:0] byte_in,
  // Decoded instruction
  input wire logic issue_q,
  input wire logic [4:0] op_q,
  input wire logic width_word_q,
  input wire logic [7:0] modrm_q,
  input wire logic [15:0] imm_q,
  input wire logic imm_valid_q,
  input wire logic [1:0] repeat_q,
  input wire logic use_count_reg_q,
  input wire logic port_from_dx_q,
  input wire logic undefined_q
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  property p_rcl;
    issue_q && op_q == `SSD_K_RCL |->
      modrm_q[5:3] == 3'h2 && modrm_q == $past(byte_in);
  endproperty
  a_rcl: assert property (p_rcl)
    else $error("rotate left carry wrong field");
  property p_rcr;
    issue_q && op_q == `SSD_K_RCR |->
      modrm_q[5:3] == 3'h3 && modrm_q == $past(byte_in);
  endproperty
  a_rcr: assert property (p_rcr)
    else $error("rotate right carry wrong field");
  property p_shl;
    issue_q && op_q == `SSD_K_SHL |-> $past(byte_in[5:3]) == 3'h4;
  endproperty
  a_shl: assert property (p_shl)
    else $error("shift left wrong field");
  property p_scan;
    issue_q && op_q == `SSD_K_SCAN |-> $past(byte_in[7:1]) == 7'h57
      && width_word_q == $past(byte_in[0]);
  endproperty
  a_scan: assert property (p_scan)
    else $error("scan from wrong byte");
  // High byte ends the return; issue lands two edges later
  property p_ret;
    issue_q && imm_valid_q |-> imm_q[15:8] == $past(byte_in, 2);
  endproperty
  a_ret: assert property (p_ret)
    else $error("return immediate high byte wrong");
  property p_undef;
    issue_q && undefined_q |-> op_q == `SSD_K_UNDEF;
  endproperty
  a_undef: assert property (p_undef)
    else $error("undefined flag without undefined op");
  property p_rep;
    issue_q && repeat_q != `SSD_RP_NONE |-> use_count_reg_q;
  endproperty
  a_rep: assert property (p_rep)
    else $error("repeat without count register");
  property p_ins;
    issue_q && op_q == `SSD_K_INS |-> port_from_dx_q;
  endproperty
  a_ins: assert property (p_ins)
    else $error("port input without port register");
endmodule
bind ssd_decoder ssd_chk ssd_chk_inst (.clk(clk), .rst(rst),
  .byte_valid(byte_valid), .byte_in(byte_in), .issue_q(issue_q),
  .op_q(op_q), .width_word_q(width_word_q), .modrm_q(modrm_q),
  .imm_q(imm_q), .imm_valid_q(imm_valid_q), .repeat_q(repeat_q),
  .use_count_reg_q(use_count_reg_q), .port_from_dx_q(port_from_dx_q),
  .undefined_q(undefined_q));
`default_nettype wire

// ==== verif/ssd_fetch_model.sv ====
// Purpose: Fetch unit model feeding the decoder
// Assumes: send is called just after a rising edge
// Notes: Idle stream shows the inverse of the last byte
`timescale 1ns/100ps
`default_nettype none
module ssd_fetch_model (
  // Clock
  input wire logic clk,
  // Byte stream
  output var logic byte_valid,
  output var logic [7:0] byte_in
);
  initial
  begin
    byte_valid = 1'b0;
    byte_in = 8'h00;
  end
  // Bytes go low byte of b first
  task send(input int n, input logic [23:0] b, input int gap);
    int i;
    @(posedge clk);
    for (i = 0; i < n; i++)
    begin
      byte_valid <= 1'b1;
      byte_in <= b[8*i +: 8];
      @(posedge clk);
      if (gap > 0 || i == n - 1)
      begin
        byte_valid <= 1'b0;
        byte_in <= ~b[8*i +: 8];
        if (i < n - 1)
          repeat (gap) @(posedge clk);
      end
    end
  endtask
endmodule
`default_nettype wire

// ==== verif/tb_top.sv ====
// Purpose: Self-checking bench for the slice decoder
// Assumes: One byte per cycle at most from the fetch model
// Notes: Expected codes come from the opcode patterns
`timescale 1ns/100ps
`default_nettype none
`include "ssd_regs.vh"
`define CHK(a, e) \
  begin check_count++; if ((a) !== (e)) begin n_fail++; \
  $display("[ERR] %0t mismatch", $time); end end
module tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  wire byte_valid, issue_q, width_word_q, dir_q, imm_valid_q;
  wire stack_seg_q, use_count_reg_q, port_from_dx_q, undefined_q;
  wire [7:0] byte_in, modrm_q;
  wire [4:0] op_q;
  wire [1:0] count_form_q, repeat_q;
  wire [15:0] imm_q;
  int n_fail = 0;
  int check_count = 0;
  always #2 clk = ~clk;
  ssd_fetch_model ssd_fetch_model_inst (.clk(clk),
    .byte_valid(byte_valid), .byte_in(byte_in));
  ssd_decoder ssd_decoder_inst (.clk(clk), .rst(rst),
    .byte_valid(byte_valid), .byte_in(byte_in), .issue_q(issue_q),
    .op_q(op_q), .width_word_q(width_word_q), .dir_q(dir_q),
    .count_form_q(count_form_q), .modrm_q(modrm_q), .imm_q(imm_q),
    .imm_valid_q(imm_valid_q), .stack_seg_q(stack_seg_q),
    .repeat_q(repeat_q), .use_count_reg_q(use_count_reg_q),
    .port_from_dx_q(port_from_dx_q), .undefined_q(undefined_q));
  task summarize;
    if (n_fail == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Issue pulse stands one cycle from the completing edge, so
  // look just after that edge first, then after each of the next seven
  task issue(input int n, input logic [23:0] b, input int gap);
    int k;
    ssd_fetch_model_inst.send(n, b, gap);
    for (k = 0; k < 8; k++)
    begin
      #1;
      if (issue_q === 1'b1)
        break;
      @(posedge clk);
    end
    if (k == 8)
    begin
      n_fail++;
      $display("[ERR] %0t no issue", $time);
      summarize();
    end
  endtask
  task s_shift;
    logic [4:0] k [8];
    logic [7:0] m8;
    int m;
    k = '{`SSD_K_ROL, `SSD_K_ROR, `SSD_K_RCL, `SSD_K_RCR,
      `SSD_K_SHL, `SSD_K_SHR, `SSD_K_UNDEF, `SSD_K_SAR};
    for (m = 0; m < 8; m++)
    begin
      m8 = {2'b11, m[2:0], 3'b001};
      // Odd fields use the by-count-register byte form
      issue(2, {8'h00, m8, m[0] ? 8'hd2 : 8'hd1}, 0);
      `CHK(op_q, k[m])
      `CHK(undefined_q, m == 6)
      `CHK(width_word_q, ~m[0])
      `CHK(count_form_q, m[0] ? `SSD_CNT_CL : `SSD_CNT_ONE)
      `CHK(modrm_q, m8)
      `CHK(use_count_reg_q, m[0])
    end
    // Count byte after the by-count form is left to the fetch unit
    issue(2, 24'h00e0c1, 0);
    `CHK(op_q, `SSD_K_SHL)
    `CHK(count_form_q, `SSD_CNT_IMM)
    `CHK(width_word_q, 1'b1)
  endtask
  task s_ret;
    issue(3, 24'h1234c2, 0);
    `CHK(op_q, `SSD_K_RETN)
    `CHK(imm_q, 16'h1234)
    `CHK(imm_valid_q, 1'b1)
    issue(3, 24'habcdca, 2);
    `CHK(op_q, `SSD_K_RETF)
    `CHK(imm_q, 16'habcd)
    `CHK(imm_valid_q, 1'b1)
    // Plain returns carry no immediate
    issue(1, 24'h0000c3, 0);
    `CHK(op_q, `SSD_K_RETN)
    `CHK(imm_valid_q, 1'b0)
    issue(1, 24'h0000cb, 0);
    `CHK(op_q, `SSD_K_RETF)
    `CHK(imm_valid_q, 1'b0)
  endtask
  task s_sbb;
    int m;
    for (m = 0; m < 4; m++)
    begin
      issue(2, {16'h00c3, 6'b000110, m[1:0]}, 0);
      `CHK(op_q, `SSD_K_SBB)
      `CHK({dir_q, width_word_q}, m[1:0])
    end
    issue(2, 24'h001081, 1);
    `CHK(undefined_q, 1'b1)
    `CHK(op_q, `SSD_K_UNDEF)
    // Immediate group with the borrow field
    issue(2, 24'h00d883, 0);
    `CHK(op_q, `SSD_K_SBB)
    `CHK(undefined_q, 1'b0)
    issue(1, 24'h00001d, 0);
    `CHK(op_q, `SSD_K_SBB)
    `CHK(width_word_q, 1'b1)
  endtask
  task s_string;
    logic [23:0] b [10];
    logic [4:0] k [10];
    logic [1:0] r [10];
    int i;
    int n;
    // Last two: repeat-not-equal on a store, then last prefix wins
    b = '{24'h00ae36, 24'h0000ae, 24'h00aff3, 24'h00aef2,
      24'h00a7f2, 24'h00a6f3, 24'h006cf3, 24'h00a4f3,
      24'h00aaf2, 24'haef3f2};
    k = '{`SSD_K_SCAN, `SSD_K_SCAN, `SSD_K_SCAN, `SSD_K_SCAN,
      `SSD_K_STRING_COMPARE, `SSD_K_STRING_COMPARE, `SSD_K_INS, `SSD_K_OTHERSTR,
      `SSD_K_OTHERSTR, `SSD_K_SCAN};
    r = '{2'h0, 2'h0, 2'h2, 2'h3, 2'h3, 2'h2, 2'h1, 2'h1, 2'h1, 2'h2};
    for (i = 0; i < 10; i++)
    begin
      n = (b[i][23:16] != 8'h00) ? 3 : (b[i][15:8] != 8'h00) ? 2 : 1;
      issue(n, b[i], 0);
      `CHK(op_q, k[i])
      `CHK(width_word_q, b[i][8*(n-1)])
      `CHK(repeat_q, r[i])
      `CHK(use_count_reg_q, r[i] != 2'h0)
      `CHK(stack_seg_q, i == 0)
      `CHK(port_from_dx_q, i == 6)
    end
  endtask
  initial
  begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    `CHK({issue_q, op_q, imm_q}, 22'h0)
    s_shift();
    s_ret();
    s_sbb();
    s_string();
    summarize();
  end
endmodule
`default_nettype wire
